/* File: e1_alarm_flags_params.svh */
// Purpose: Constants of the E1 alarm event flag block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Operation summary below
//
// Operation
// - Pool ready flag rises while transmit FIFO has room for 32 more bytes.
// - Reading the framer alarm event register clears all its flags.
// - Reading the timing alarm event register clears all its flags.
// - Masked-visible mode records masked events but keeps them off irq and summary.
// - Frame regained set on frame loss status clearing or sim end while in sync.
// - Frame lost set when loss status rises, and during alarm simulation.
// - CRC mode only: multiframe pair found sets regain, clears multiframe lost status.
// - Timeout set after 400 ms multiframe search with basic framing; never in sync.
// - All-ones flag on status rise or simulation; any change when change select set.
// - No-signal flag on status rise or simulation; any change when change select set.
// - Remote alarm cleared on status fall, or simulation end with no alarm.
// - Remote alarm flag on status rise, and during alarm simulation.
// - Errored second set when an enabled source occurred during the second.
// - Errored second mask selects among eight listed error sources.
// - One second tick from recovered receive clock count or external pin.
// - TS16 multiframe lost after two missed patterns or 16 zero octets.
// - TS16 all-ones status: under 4 zeros in each of two consecutive multiframes; flag on change.
// - TS16 remote alarm change flag set when that word bit changes.
// - Negative slip pulse, or alarm simulation, sets the skip slip flag.
// - Positive slip pulse, or alarm simulation, sets the repeat slip flag.
// - Summary holds one pending bit per event register, unmasked events only.
`ifndef E1_ALARM_FLAGS_PARAMS_SVH
`define E1_ALARM_FLAGS_PARAMS_SVH

// Register byte addresses
`define ADR_FRAMER_EVT  8'h00
`define ADR_TIMING_EVT  8'h04
`define ADR_MASK_TWO    8'h08
`define ADR_MASK_THREE  8'h0C
`define ADR_SUMMARY     8'h10
`define ADR_CONTROL     8'h14
`define ADR_ES_MASK     8'h18
`define ADR_STATUS      8'h1C

// Framer alarm event bits
`define FA_REGAIN   7
`define FA_LOST     6
`define FA_MF_REG   5
`define FA_TIMEOUT  4
`define FA_AIS      3
`define FA_LOS      2
`define FA_RALM_CLR 1
`define FA_RALM     0

// Timing alarm event bits
`define TA_ES       7
`define TA_SEC      6
`define TA_TS16_LOST 5
`define TA_TS16_ONES 4
`define TA_TS16_RALM 3
`define TA_SKIP     2
`define TA_REPEAT   1

// Control and summary bits
`define CTL_VIS     0
`define CTL_SCI     1
`define CTL_SECSRC  2
`define SUM_FAE     2
`define SUM_TAE     3

// Reset values
`define RST_MASK    8'h00
`define RST_CTRL    8'h00
`define RST_ES_MASK 8'h00

// Timing
`define RX_CLK_KHZ       2048
`define LONG_SEARCH_MS   400
`define ONE_SEC_MS       1000
`define RX_TICKS_PER_MS  (`RX_CLK_KHZ)
`define RX_TICKS_PER_SEC (`ONE_SEC_MS * `RX_TICKS_PER_MS)
`define TX_POOL_BYTES    32
`define TS16_MISS_LIMIT  2
`define TS16_ZERO_LIMIT  16
`define TS16_AIS_ZEROS   4

`endif

/* File: e1_alarm_flags_pkg.sv */
// Purpose: Types of the E1 alarm event flag block
// Assumes: Nothing beyond the constants header
// Notes:   Source selector for the one second timer
package e1_alarm_flags_pkg;
    typedef logic [7:0] evt_byte_t;
    typedef enum logic [0:0] {
        SEC_FROM_RXCLK = 1'b0,
        SEC_FROM_PIN   = 1'b1
    } sec_src_t;
endpackage

/* File: e1_framer_alarm_event_flags.sv */
// Purpose: Sticky alarm event flags of one E1 framer channel
// Assumes: Framer status inputs synchronous to core_clk, pulses one cycle
// Notes:   Registers reached over classic Wishbone, one-wait ack
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "e1_alarm_flags_params.svh"

module e1_framer_alarm_event_flags
    import e1_alarm_flags_pkg::*;
#(
    parameter int unsigned SEC_TICKS = `RX_TICKS_PER_SEC,
    parameter int unsigned TICK_MS   = `RX_TICKS_PER_MS,
    parameter int unsigned SEARCH_MS = `LONG_SEARCH_MS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Framer conditions
    input  wire logic        alarm_sim,
    input  wire logic        frame_sync_lost_status,
    input  wire logic        crc_mf_mode,
    input  wire logic        multiframe_en,
    input  wire logic        mf_pair_found,
    input  wire logic        ais_status,
    input  wire logic        los_status,
    input  wire logic        remote_alarm_status,
    // Error sources and slips
    input  wire logic        framing_error_source,
    input  wire logic        crc_error_source,
    input  wire logic        code_violation_source,
    input  wire logic        far_end_block_error_source,
    input  wire logic        rx_slip_skip,
    input  wire logic        rx_slip_repeat,
    // Timing sources
    input  wire logic        rx_clk_tick,
    input  wire logic        external_one_hertz_pin,
    // Time slot 16 stream
    input  wire logic        ts16_octet_stb,
    input  wire logic [7:0]  ts16_octet,
    input  wire logic        ts16_mf_stb,
    input  wire logic        ts16_mf_word_ok,
    input  wire logic        ts16_remote_alarm_bit,
    // Transmit FIFO room
    input  wire logic [6:0]  tx_fifo_free,
    // Status outputs
    output logic             tx_pool_ready_flag,
    output logic             multiframe_lost_status,
    output logic             ts16_multiframe_lost_status,
    output logic             ts16_all_ones_status,
    output logic             irq_out
);

    //--------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------
    localparam int SW = $clog2(SEC_TICKS + 1);
    localparam int MW = $clog2(TICK_MS + 1);
    localparam int LW = $clog2(SEARCH_MS + 1);

    logic          ack_ff,     nxt_ack;
    logic [31:0]   dat_ff,     nxt_dat;
    evt_byte_t     fae_ff,     nxt_fae;
    evt_byte_t     tae_ff,     nxt_tae;
    evt_byte_t     mask2_ff,   nxt_mask2;
    evt_byte_t     mask3_ff,   nxt_mask3;
    evt_byte_t     es_mask_ff, nxt_es_mask;
    logic [2:0]    ctrl_ff,    nxt_ctrl;
    logic          irq_ff,     nxt_irq;
    logic          pool_ff,    nxt_pool;
    logic          mf_lost_ff, nxt_mf_lost;
    logic [7:0]    prev_ff,    nxt_prev;
    logic [SW-1:0] sec_cnt_ff, nxt_sec_cnt;
    logic [MW-1:0] ms_cnt_ff,  nxt_ms_cnt;
    logic [LW-1:0] srch_ff,    nxt_srch;
    logic          es_lat_ff,  nxt_es_lat;
    logic [1:0]    miss_ff,    nxt_miss;
    logic [4:0]    zoct_ff,    nxt_zoct;
    logic          lost16_ff,  nxt_lost16;
    logic [7:0]    zsum_ff,    nxt_zsum;
    logic          low_ff,     nxt_low;
    logic          ones16_ff,  nxt_ones16;
    logic          ralm16_ff,  nxt_ralm16;

    logic          req;
    logic          wr_now;
    logic          rd_fae_now;
    logic          rd_tae_now;
    logic          vis;
    logic          sci;
    logic          sim_end;
    logic          ms_tick;
    logic          sec_tick;
    logic          srch_on;
    evt_byte_t     fae_set;
    evt_byte_t     tae_set;
    evt_byte_t     fae_rec;
    evt_byte_t     tae_rec;
    evt_byte_t     es_src;
    logic          fae_pend;
    logic          tae_pend;
    logic [7:0]    zeros_now;
    logic [31:0]   rd_word;

    //--------------------------------------------------------------
    // Bus decode and event detection
    //--------------------------------------------------------------
    // Access qualifiers and timing ticks
    always_comb begin
        req        = wb_cyc_i & wb_stb_i & ~ack_ff;
        wr_now     = req & wb_we_i & wb_sel_i[0];
        rd_fae_now = req & ~wb_we_i & (wb_adr_i == `ADR_FRAMER_EVT);
        rd_tae_now = req & ~wb_we_i & (wb_adr_i == `ADR_TIMING_EVT);
        vis        = ctrl_ff[`CTL_VIS];
        sci        = ctrl_ff[`CTL_SCI];
        sim_end    = prev_ff[7] & ~alarm_sim;
        ms_tick    = rx_clk_tick & (ms_cnt_ff == MW'(TICK_MS - 1));
        if (sec_src_t'(ctrl_ff[`CTL_SECSRC]) == SEC_FROM_PIN) begin
            sec_tick = external_one_hertz_pin & ~prev_ff[6];
        end else begin
            sec_tick = rx_clk_tick & (sec_cnt_ff == SW'(SEC_TICKS - 1));
        end
        srch_on    = multiframe_en & ~frame_sync_lost_status & mf_lost_ff;
        zeros_now  = 8'(8 - $countones(ts16_octet));
    end

    // Raw events of the framer alarm group
    always_comb begin
        fae_set = 8'h00;
        fae_set[`FA_REGAIN] = (prev_ff[0] & ~frame_sync_lost_status)
                            | (sim_end & ~frame_sync_lost_status);
        fae_set[`FA_LOST]   = (frame_sync_lost_status & ~prev_ff[0]) | alarm_sim;
        fae_set[`FA_MF_REG] = crc_mf_mode & ((mf_pair_found & ~frame_sync_lost_status)
                            | (sim_end & ~frame_sync_lost_status));
        fae_set[`FA_TIMEOUT] = srch_on & ms_tick
                             & (srch_ff == LW'(SEARCH_MS - 1));
        fae_set[`FA_AIS]    = (ais_status & ~prev_ff[1])
                            | (sci & ~ais_status & prev_ff[1]) | alarm_sim;
        fae_set[`FA_LOS]    = (los_status & ~prev_ff[2])
                            | (sci & ~los_status & prev_ff[2]) | alarm_sim;
        fae_set[`FA_RALM_CLR] = (prev_ff[3] & ~remote_alarm_status)
                              | (sim_end & ~remote_alarm_status);
        fae_set[`FA_RALM]     = (remote_alarm_status & ~prev_ff[3]) | alarm_sim;
    end

    // Raw events of the timing alarm group and errored-second sources
    always_comb begin
        es_src = {frame_sync_lost_status, framing_error_source, crc_error_source,
                  ais_status, los_status, code_violation_source,
                  rx_slip_skip | rx_slip_repeat, far_end_block_error_source};
        tae_set = 8'h00;
        tae_set[`TA_ES]     = sec_tick & (es_lat_ff | (|(es_src & es_mask_ff)));
        tae_set[`TA_SEC]    = sec_tick;
        tae_set[`TA_TS16_LOST] = (nxt_lost16 & ~lost16_ff)
                               | (sci & ~nxt_lost16 & lost16_ff);
        tae_set[`TA_TS16_ONES] = nxt_ones16 ^ ones16_ff;
        tae_set[`TA_TS16_RALM] = nxt_ralm16 ^ ralm16_ff;
        tae_set[`TA_SKIP]   = rx_slip_skip | alarm_sim;
        tae_set[`TA_REPEAT] = rx_slip_repeat | alarm_sim;
    end

    // Recording gates and pending terms
    always_comb begin
        fae_rec  = ~mask2_ff | {8{vis}};
        tae_rec  = ~mask3_ff | {8{vis}};
        fae_pend = |(fae_ff & ~mask2_ff);
        tae_pend = |(tae_ff & ~mask3_ff);
    end

    // Read multiplexer
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            `ADR_FRAMER_EVT: rd_word[7:0] = fae_ff;
            `ADR_TIMING_EVT: rd_word[7:0] = tae_ff;
            `ADR_MASK_TWO:   rd_word[7:0] = mask2_ff;
            `ADR_MASK_THREE: rd_word[7:0] = mask3_ff;
            `ADR_SUMMARY: begin
                rd_word[`SUM_FAE] = fae_pend;
                rd_word[`SUM_TAE] = tae_pend;
            end
            `ADR_CONTROL:    rd_word[2:0] = ctrl_ff;
            `ADR_ES_MASK:    rd_word[7:0] = es_mask_ff;
            `ADR_STATUS:     rd_word[3:0] = {ones16_ff, lost16_ff, mf_lost_ff, pool_ff};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    // Bus, configuration and flag registers
    always_comb begin
        nxt_ack   = req;
        nxt_dat   = req ? rd_word : dat_ff;
        nxt_mask2 = mask2_ff;
        nxt_mask3 = mask3_ff;
        nxt_es_mask = es_mask_ff;
        nxt_ctrl  = ctrl_ff;
        if (wr_now) begin
            unique case (wb_adr_i)
                `ADR_MASK_TWO:   nxt_mask2 = wb_dat_i[7:0];
                `ADR_MASK_THREE: nxt_mask3 = wb_dat_i[7:0];
                `ADR_CONTROL:    nxt_ctrl  = wb_dat_i[2:0];
                `ADR_ES_MASK:    nxt_es_mask = wb_dat_i[7:0];
                default:         nxt_ctrl  = ctrl_ff;
            endcase
        end
        // Set wins over the read clear
        nxt_fae  = (rd_fae_now ? 8'h00 : fae_ff) | (fae_set & fae_rec);
        nxt_tae  = (rd_tae_now ? 8'h00 : tae_ff) | (tae_set & tae_rec);
        nxt_irq  = fae_pend | tae_pend;
        nxt_pool = tx_fifo_free >= 7'(`TX_POOL_BYTES);
        nxt_prev = {alarm_sim, external_one_hertz_pin, 2'b00, remote_alarm_status,
                    los_status, ais_status, frame_sync_lost_status};
    end

    // Multiframe search, timers and errored-second latch
    always_comb begin
        nxt_mf_lost = mf_lost_ff;
        if (frame_sync_lost_status & ~prev_ff[0]) begin
            nxt_mf_lost = 1'b1;
        end else if (crc_mf_mode & mf_pair_found) begin
            nxt_mf_lost = 1'b0;
        end
        nxt_ms_cnt = ms_cnt_ff;
        if (rx_clk_tick) begin
            nxt_ms_cnt = ms_tick ? '0 : MW'(ms_cnt_ff + 1'b1);
        end
        nxt_sec_cnt = sec_cnt_ff;
        if (rx_clk_tick) begin
            nxt_sec_cnt = (sec_cnt_ff == SW'(SEC_TICKS - 1)) ? '0 : SW'(sec_cnt_ff + 1'b1);
        end
        nxt_srch = srch_ff;
        if (!srch_on) begin
            nxt_srch = '0;
        end else if (ms_tick && srch_ff < LW'(SEARCH_MS)) begin
            nxt_srch = LW'(srch_ff + 1'b1);
        end
        nxt_es_lat = es_lat_ff | (|(es_src & es_mask_ff));
        if (sec_tick) begin
            nxt_es_lat = 1'b0;
        end
    end

    // Time slot 16 alignment, all-ones and remote alarm tracking
    always_comb begin
        nxt_miss   = miss_ff;
        nxt_zoct   = zoct_ff;
        nxt_lost16 = lost16_ff;
        nxt_zsum   = zsum_ff;
        nxt_low    = low_ff;
        nxt_ones16 = ones16_ff;
        nxt_ralm16 = ralm16_ff;
        if (ts16_octet_stb) begin
            nxt_zoct = (ts16_octet != 8'h00) ? 5'h00
                     : (zoct_ff == 5'(`TS16_ZERO_LIMIT)) ? zoct_ff : 5'(zoct_ff + 1'b1);
            nxt_zsum = (zsum_ff > 8'hF7) ? 8'hFF : 8'(zsum_ff + zeros_now);
            if (ts16_octet == 8'h00 && zoct_ff == 5'(`TS16_ZERO_LIMIT - 1)) begin
                nxt_lost16 = 1'b1;
            end
        end
        if (ts16_mf_stb) begin
            if (ts16_mf_word_ok) begin
                nxt_miss   = 2'h0;
                nxt_lost16 = 1'b0;
            end else begin
                nxt_miss = (miss_ff == 2'(`TS16_MISS_LIMIT)) ? miss_ff : 2'(miss_ff + 1'b1);
                if (miss_ff == 2'(`TS16_MISS_LIMIT - 1)) begin
                    nxt_lost16 = 1'b1;
                end
            end
            nxt_low   = zsum_ff < 8'(`TS16_AIS_ZEROS);
            nxt_ones16 = low_ff & (zsum_ff < 8'(`TS16_AIS_ZEROS));
            nxt_zsum   = 8'h00;
            nxt_ralm16 = ts16_remote_alarm_bit;
        end
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    // All state, synchronous reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
            fae_ff <= 8'h00;
            tae_ff <= 8'h00;
            mask2_ff <= `RST_MASK;
            mask3_ff <= `RST_MASK;
            es_mask_ff <= `RST_ES_MASK;
            ctrl_ff <= 3'(`RST_CTRL);
            irq_ff <= 1'b0;
            pool_ff <= 1'b0;
            mf_lost_ff <= 1'b1;
            prev_ff <= 8'h00;
            sec_cnt_ff <= '0;
            ms_cnt_ff <= '0;
            srch_ff <= '0;
            es_lat_ff <= 1'b0;
            miss_ff <= 2'h0;
            zoct_ff <= 5'h00;
            lost16_ff <= 1'b1;
            zsum_ff <= 8'h00;
            low_ff <= 1'b0;
            ones16_ff <= 1'b0;
            ralm16_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            fae_ff <= nxt_fae;
            tae_ff <= nxt_tae;
            mask2_ff <= nxt_mask2;
            mask3_ff <= nxt_mask3;
            es_mask_ff <= nxt_es_mask;
            ctrl_ff <= nxt_ctrl;
            irq_ff <= nxt_irq;
            pool_ff <= nxt_pool;
            mf_lost_ff <= nxt_mf_lost;
            prev_ff <= nxt_prev;
            sec_cnt_ff <= nxt_sec_cnt;
            ms_cnt_ff <= nxt_ms_cnt;
            srch_ff <= nxt_srch;
            es_lat_ff <= nxt_es_lat;
            miss_ff <= nxt_miss;
            zoct_ff <= nxt_zoct;
            lost16_ff <= nxt_lost16;
            zsum_ff <= nxt_zsum;
            low_ff <= nxt_low;
            ones16_ff <= nxt_ones16;
            ralm16_ff <= nxt_ralm16;
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o                    = ack_ff;
    assign wb_dat_o                    = dat_ff;
    assign irq_out                     = irq_ff;
    assign tx_pool_ready_flag          = pool_ff;
    assign multiframe_lost_status      = mf_lost_ff;
    assign ts16_multiframe_lost_status = lost16_ff;
    assign ts16_all_ones_status        = ones16_ff;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_fae_read_quiet;
        rd_fae_now && (fae_set == 8'h00);
    endsequence

    sequence s_tae_read_quiet;
        rd_tae_now && (tae_set == 8'h00);
    endsequence

    a_read_clears_fae: assert property (s_fae_read_quiet |=> fae_ff == 8'h00)
        else $error("framer events not cleared by read");
    a_read_clears_tae: assert property (s_tae_read_quiet |=> tae_ff == 8'h00)
        else $error("timing events not cleared by read");
    a_masked_recorded: assert property (vis && !rd_fae_now ##1 1 |->
        ((fae_ff & $past(fae_set)) == $past(fae_set)))
        else $error("masked event not recorded");
    a_irq_mask_gate: assert property (((fae_ff & ~mask2_ff) == 8'h00)
        && ((tae_ff & ~mask3_ff) == 8'h00) |=> !irq_out)
        else $error("irq raised by masked events");
    a_lost_on_rise: assert property ($rose(frame_sync_lost_status) && fae_rec[`FA_LOST]
        |-> ##1 fae_ff[`FA_LOST])
        else $error("frame lost flag missing");
    a_regain_on_fall: assert property ($fell(frame_sync_lost_status)
        && fae_rec[`FA_REGAIN] |-> ##1 fae_ff[`FA_REGAIN])
        else $error("frame regained flag missing");
    a_mf_clears_lost: assert property (crc_mf_mode && mf_pair_found
        && !(frame_sync_lost_status && !prev_ff[0]) |=> !multiframe_lost_status)
        else $error("multiframe lost status not cleared");
    a_timeout_not_sync: assert property (!multiframe_lost_status && !rd_fae_now
        && !fae_ff[`FA_TIMEOUT] |=> !fae_ff[`FA_TIMEOUT])
        else $error("search timeout outside search");
    a_flags_sticky: assert property (!rd_fae_now |=>
        ((fae_ff & $past(fae_ff)) == $past(fae_ff)))
        else $error("framer flag dropped without read");
    a_pool_ready: assert property ((tx_fifo_free >= 7'(`TX_POOL_BYTES)) [*2]
        |-> tx_pool_ready_flag)
        else $error("pool ready flag missing");
    a_sec_records: assert property (sec_tick && tae_rec[`TA_SEC]
        |=> tae_ff[`TA_SEC])
        else $error("second tick not recorded");
    a_ack_single: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");

endmodule

/* File: e1_framer_alarm_event_flags_tb_top.sv */
// Purpose: Self-checking bench of the E1 alarm event flag block
// Assumes: Short second, millisecond and search counts set by parameters
// Notes:   Expected flag bytes inline for checked reads; reset values from a table
`timescale 1ns/1ps
module e1_framer_alarm_event_flags_tb_top;
    import e1_alarm_flags_pkg::*;
    // ------------------------------------------------------------
    // Signals and reset table
    // ------------------------------------------------------------
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        core_clk, rst, cyc, stb, we, ack, irq, pool, mfl, t16l, t16a;
    logic        sim, fsl, crc, mfen, pair, all_ones_alarm_flag, no_signal_flag, ralm, frm_err, crc_err, cv_err, eb_err;
    logic        skip, rep, tick, pin, ostb, mstb, wok, rbit;
    logic [7:0]  adr, oct, dat;
    logic [3:0]  sel;
    logic [31:0] dat_o, q;
    logic [6:0]  free;
    int          n_errors, compares, v;
    logic [7:0]  radr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [7:0]  rexp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00};

    e1_framer_alarm_event_flags #(.SEC_TICKS(50), .TICK_MS(4), .SEARCH_MS(3))
    u_e1_framer_alarm_event_flags (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i({24'h0, dat}), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .alarm_sim(sim), .frame_sync_lost_status(fsl), .crc_mf_mode(crc),
        .multiframe_en(mfen), .mf_pair_found(pair), .ais_status(all_ones_alarm_flag), .los_status(no_signal_flag),
        .remote_alarm_status(ralm), .framing_error_source(frm_err),
        .crc_error_source(crc_err), .code_violation_source(cv_err),
        .far_end_block_error_source(eb_err),
        .rx_slip_skip(skip), .rx_slip_repeat(rep), .rx_clk_tick(tick),
        .external_one_hertz_pin(pin), .ts16_octet_stb(ostb), .ts16_octet(oct),
        .ts16_mf_stb(mstb), .ts16_mf_word_ok(wok), .ts16_remote_alarm_bit(rbit),
        .tx_fifo_free(free), .tx_pool_ready_flag(pool), .multiframe_lost_status(mfl),
        .ts16_multiframe_lost_status(t16l), .ts16_all_ones_status(t16a), .irq_out(irq));

    // ------------------------------------------------------------
    // Clock, watchdog and helper tasks
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 8'h00);
        chk(q & m, e);
    endtask
    task idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task ticks(input int n);
        repeat (n) begin
            @(posedge core_clk) tick <= 1'b1;
            @(posedge core_clk) tick <= 1'b0;
        end
    endtask
    // One signaling multiframe check with word result and alarm bit
    task mf(input logic ok, input logic r);
        @(posedge core_clk) {mstb, wok, rbit} <= {1'b1, ok, r};
        @(posedge core_clk) mstb <= 1'b0;
        idle(1);
    endtask
    task wrap_up;
        $display("Compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {cyc, stb, we, sim, fsl, mfen, pair, all_ones_alarm_flag, no_signal_flag, frm_err, crc_err, cv_err, eb_err} = '0;
        {ralm, skip, rep, tick, pin, ostb, mstb, wok, rbit} = '0;
        {adr, oct, dat, free} = '0;
        crc = 1'b1;
        sel = 4'hF;
        rst = 1'b1;
        void'($urandom(32'hEA57848C));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        idle(1);
        foreach (radr[i]) rd(radr[i], ALL, {24'h0, rexp[i]});
        wr_mask: begin
            wb(1'b1, 8'h08, 8'h08);
            @(posedge core_clk) sel <= 4'h0;
            wb(1'b1, 8'h08, 8'hFF);
            sel <= 4'hF;
            rd(8'h08, ALL, 32'h08);
            wb(1'b1, 8'h00, 8'hFF);
        end
        @(posedge core_clk) all_ones_alarm_flag <= 1'b1;
        idle(3);
        rd(8'h00, ALL, 32'h00);
        wb(1'b1, 8'h14, 8'h01);
        @(posedge core_clk) all_ones_alarm_flag <= 1'b0;
        @(posedge core_clk) all_ones_alarm_flag <= 1'b1;
        idle(3);
        chk(irq, 1'b0);
        rd(8'h10, ALL, 32'h00);
        rd(8'h00, ALL, 32'h08);
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b1, 8'h14, 8'h02);
        @(posedge core_clk) no_signal_flag <= 1'b1;
        @(posedge core_clk) no_signal_flag <= 1'b0;
        idle(3);
        chk(irq, 1'b1);
        rd(8'h10, ALL, 32'h04);
        rd(8'h00, ALL, 32'h04);
        idle(2);
        chk(irq, 1'b0);
        rd(8'h00, ALL, 32'h00);
        @(posedge core_clk) skip <= 1'b1;
        @(posedge core_clk) {skip, rep} <= 2'b01;
        @(posedge core_clk) rep <= 1'b0;
        idle(2);
        rd(8'h04, ALL, 32'h06);
        rd(8'h04, ALL, 32'h00);
        @(posedge core_clk) sim <= 1'b1;
        repeat (3) @(posedge core_clk);
        sim <= 1'b0;
        idle(3);
        rd(8'h00, ALL, 32'hEF);
        rd(8'h04, ALL, 32'h06);
        @(posedge core_clk) {mfen, fsl} <= 2'b11;
        repeat (2) @(posedge core_clk);
        fsl <= 1'b0;
        ticks(20);
        idle(1);
        chk(mfl, 1'b1);
        rd(8'h00, 32'hD0, 32'hD0);
        @(posedge core_clk) pair <= 1'b1;
        @(posedge core_clk) pair <= 1'b0;
        idle(2);
        chk(mfl, 1'b0);
        ticks(20);
        rd(8'h00, 32'h30, 32'h20);
        wb(1'b0, 8'h04, 8'h00);
        wb(1'b1, 8'h18, 8'h60);
        @(posedge core_clk) frm_err <= 1'b1;
        @(posedge core_clk) {frm_err, crc_err} <= 2'b01;
        @(posedge core_clk) crc_err <= 1'b0;
        ticks(50);
        rd(8'h04, 32'hC0, 32'hC0);
        wb(1'b1, 8'h14, 8'h04);
        @(posedge core_clk) pin <= 1'b1;
        idle(3);
        rd(8'h04, 32'h40, 32'h40);
        mf(1'b1, 1'b1);
        chk(t16l, 1'b0);
        rd(8'h04, 32'h08, 32'h08);
        mf(1'b1, 1'b1);
        chk(t16a, 1'b1);
        rd(8'h04, 32'h18, 32'h10);
        repeat (15) @(posedge core_clk) {ostb, oct} <= 9'h100;
        @(posedge core_clk) ostb <= 1'b0;
        idle(1);
        chk(t16l, 1'b0);
        @(posedge core_clk) ostb <= 1'b1;
        @(posedge core_clk) ostb <= 1'b0;
        idle(1);
        chk(t16l, 1'b1);
        rd(8'h04, 32'h20, 32'h20);
        mf(1'b1, 1'b0);
        chk(t16a, 1'b0);
        mf(1'b0, 1'b0);
        chk(t16l, 1'b0);
        mf(1'b0, 1'b0);
        chk(t16l, 1'b1);
        wb(1'b0, 8'h04, 8'h00);
        wb(1'b1, 8'h0C, 8'hFF);
        mf(1'b1, 1'b1);
        rd(8'h04, ALL, 32'h00);
        for (int i = 0; i < 8; i++) begin
            v = (i < 2) ? 31 + i : $urandom_range(127, 0);
            @(posedge core_clk) free <= 7'(v);
            idle(2);
            chk(pool, v >= 32);
        end
        wrap_up();
    end
endmodule
